// *** hw/mag_irq_params.svh ***
// register offsets, field positions, reset values of the mag irq block
// assumes: included by bare name from the irq_source and top design files
`ifndef MAG_IRQ_PARAMS_SVH
`define MAG_IRQ_PARAMS_SVH
// hard-iron offset bytes, x low first
`define HI_FIRST_OFS   8'h45
`define HI_LAST_OFS    8'h4a
`define CFG_B_OFS      8'h61
`define CFG_C_OFS      8'h62
`define INT_CTRL_OFS   8'h63
`define INT_SRC_OFS    8'h64
`define THS_L_OFS      8'h65
`define THS_H_OFS      8'h66
// corrected output data, x low first
`define OUT_FIRST_OFS  8'h68
`define OUT_LAST_OFS   8'h6d
// interrupt control fields
`define ICTL_IEN       0
`define ICTL_IEL       1
`define ICTL_IEA       2
`define ICTL_ZEN       5
`define ICTL_XEN       7
// configuration fields
`define CFGB_CMPSEL    3
`define CFGC_STEST     1
`define CFGC_PIN       6
// source register fields
`define SRC_INT        0
`define SRC_RANGE_OVERFLOW_FLAG       1
`define REG_RST        8'h00
`define SMP_RST        16'h0000
`endif

// *** hw/mag_irq_pkg.sv ***
// types shared by the mag irq block
// assumes: nothing
package mag_irq_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] sample_t;
  typedef logic [14:0] thresh_t;
  typedef logic [2:0]  axis_t;
endpackage

// *** hw/irq_event_if.sv ***
// per-axis compare results travelling to the source register logic
// assumes: one clock, driven by the top module
`timescale 1ns/10ps
`default_nettype none
interface irq_event_if;
  import mag_irq_pkg::*;
  logic  evalStb;
  axis_t above;
  axis_t below;
  modport cmp_side (output evalStb, above, below);
  modport src_side (input evalStb, above, below);
endinterface
`default_nettype wire

// *** hw/axis_threshold_cmp.sv ***
// one axis compared against the symmetric threshold
// assumes: purely combinational, sample in two's complement
`timescale 1ns/10ps
`default_nettype none
module axis_threshold_cmp
  import mag_irq_pkg::*;
(
  // compare inputs
  input  wire sample_t sample,
  input  wire thresh_t thresh,
  input  wire logic    axisEn,
  // results
  output logic         above,
  output logic         below
);
  logic signed [16:0] sExt;
  logic signed [16:0] limP;
  logic signed [16:0] limN;
  assign sExt  = {sample[15], sample};
  assign limP  = {2'b00, thresh};
  assign limN  = 17'(-limP);
  assign above = axisEn && (sExt > limP);
  assign below = axisEn && (sExt < limN);
endmodule
`default_nettype wire

// *** hw/irq_source.sv ***
// source flags: per-axis crossings, global event and range overflow
// assumes: evalStb is one cycle per new sample set, same clock
`timescale 1ns/10ps
`default_nettype none
`include "mag_irq_params.svh"
module irq_source
  import mag_irq_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // compare results
  irq_event_if.src_side ev,
  // control
  input  wire logic irq_master_enable,
  input  wire logic latch_select,
  input  wire logic ovf,
  input  wire logic srcRead,
  // status
  output byte_t     srcByte,
  output logic      intLvl
);
  axis_t posFlag_r;
  axis_t negFlag_r;
  logic  range_overflow_flag_r;
  axis_t posNew;
  axis_t negNew;
  axis_t posKeep;
  axis_t negKeep;
  assign posNew  = irq_master_enable ? ev.above : 3'h0;
  assign negNew  = irq_master_enable ? ev.below : 3'h0;
  assign posKeep = (latch_select && srcRead) ? 3'h0 : posFlag_r;
  assign negKeep = (latch_select && srcRead) ? 3'h0 : negFlag_r;
  assign intLvl  = |{posFlag_r, negFlag_r};
  assign srcByte = {posFlag_r, negFlag_r, range_overflow_flag_r, intLvl};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      posFlag_r <= 3'h0;
      negFlag_r <= 3'h0;
    end else if (ev.evalStb) begin
      posFlag_r <= latch_select ? (posKeep | posNew) : posNew;
      negFlag_r <= latch_select ? (negKeep | negNew) : negNew;
    end else begin
      posFlag_r <= latch_select ? posKeep : posFlag_r;
      negFlag_r <= latch_select ? negKeep : negFlag_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      range_overflow_flag_r <= 1'b0;
    else
      range_overflow_flag_r <= (irq_master_enable && ovf) || (range_overflow_flag_r && !srcRead);
  end

  property pulsedFollow_p;
    @(posedge clk) disable iff (!nrst)
      ev.evalStb && irq_master_enable && !latch_select |=> posFlag_r == $past(ev.above);
  endproperty
  pulsed_follow_a: assert property (pulsedFollow_p)
    else $error("pulsed flags do not follow comparison");
  latch_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    intLvl && latch_select && !srcRead |=> intLvl)
    else $error("latched event lost without source read");
  read_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    latch_select && srcRead && !ev.evalStb |=> !intLvl)
    else $error("source read did not clear latched event");
  overflow_set_a: assert property (@(posedge clk) disable iff (!nrst)
    ovf |=> range_overflow_flag_r == ($past(irq_master_enable) || $past(range_overflow_flag_r && !srcRead)))
    else $error("range overflow flag wrong");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    ev.evalStb && !irq_master_enable && !latch_select |=> !intLvl)
    else $error("event raised with master enable off");
endmodule
`default_nettype wire

// *** hw/mag_hard_iron_threshold_irq.sv ***
// magnetometer post-processing: hard-iron subtraction, threshold irq, self-test
// assumes: raw samples and overflow come from logic on clk; host port is
// the device's internal register access, one byte per strobe
`timescale 1ns/10ps
`default_nettype none
`include "mag_irq_params.svh"
// Notes on behaviour
// - six writable hard-iron bytes live at 45h through 4Ah
// - high and low byte form a signed 16-bit offset per axis
// - each stored offset is subtracted from the raw axis sample
// - threshold events occur only with the master enable set
// - x, y and z enables include or exclude each axis
// - threshold is a 15-bit magnitude used as plus and minus limit
// - a crossing on an enabled axis raises the event and global flag
// - per-axis positive and negative flags record which limit was crossed
// - no new event while all enabled samples lie inside the limits
// - compare select: 0 raw samples, 1 corrected samples
// - latch select 0: interrupt follows the comparison
// - latch select 1: interrupt holds until the source register is read
// - polarity bit 1 active high, 0 active low
// - overflow flag set only with master enable, cleared on source read
// - self-test bit drives the internal coil on and off
// - writing 40h to config c routes the interrupt onto the pin
// - outputs are 16-bit two's complement in high and low bytes
module mag_hard_iron_threshold_irq
  import mag_irq_pkg::*;
#(
  parameter int DATA_W = 16
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // register access
  input  wire logic  wrEn,
  input  wire logic  rdEn,
  input  wire byte_t addr,
  input  wire byte_t wdata,
  output byte_t      rdata_r,
  // raw sample set from the converter
  input  wire logic    sampleValid,
  input  wire sample_t rawX,
  input  wire sample_t rawY,
  input  wire sample_t rawZ,
  input  wire logic    rangeOvf,
  // corrected output data
  output logic    outValid_r,
  output sample_t outX_r,
  output sample_t outY_r,
  output sample_t outZ_r,
  // self-test coil and event pin
  output logic selfTestEn_r,
  output logic eventReadyPin_r,
  output logic eventReadyPinOe_r
);
  generate
    if (DATA_W != 16) begin : g_bad_width
      $error("DATA_W must be 16");
    end
  endgenerate

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  byte_t   hi_r [6];
  byte_t   cfgB_r;
  byte_t   cfgC_r;
  byte_t   intCtrl_r;
  byte_t   thsL_r;
  byte_t   thsH_r;
  sample_t out_r [3];
  sample_t raw [3];
  sample_t off [3];
  sample_t corr [3];
  sample_t cmpIn [3];
  axis_t   axisEn;
  thresh_t thresh;
  byte_t   srcByte;
  byte_t   rdMux;
  byte_t   hiIdx8;
  byte_t   outIdx8;
  logic    hiSel;
  logic    outSel;
  logic    wrCfgB;
  logic    wrCfgC;
  logic    wrCtrl;
  logic    wrThsL;
  logic    wrThsH;
  logic    srcRead;
  logic    intLvl;
  logic    irq_master_enable;
  logic    latch_select;
  logic    output_polarity_select;
  logic    cmpSel;

  assign hiSel   = (addr >= `HI_FIRST_OFS) && (addr <= `HI_LAST_OFS);
  assign outSel  = (addr >= `OUT_FIRST_OFS) && (addr <= `OUT_LAST_OFS);
  assign hiIdx8  = addr - `HI_FIRST_OFS;
  assign outIdx8 = addr - `OUT_FIRST_OFS;
  assign wrCfgB  = wrEn && (addr == `CFG_B_OFS);
  assign wrCfgC  = wrEn && (addr == `CFG_C_OFS);
  assign wrCtrl  = wrEn && (addr == `INT_CTRL_OFS);
  assign wrThsL  = wrEn && (addr == `THS_L_OFS);
  assign wrThsH  = wrEn && (addr == `THS_H_OFS);
  assign srcRead = rdEn && (addr == `INT_SRC_OFS);

  assign irq_master_enable    = intCtrl_r[`ICTL_IEN];
  assign latch_select    = intCtrl_r[`ICTL_IEL];
  assign output_polarity_select    = intCtrl_r[`ICTL_IEA];
  assign axisEn = intCtrl_r[`ICTL_XEN:`ICTL_ZEN];
  assign cmpSel = cfgB_r[`CFGB_CMPSEL];
  // top bit of the high byte is not part of the magnitude
  assign thresh = {thsH_r[6:0], thsL_r};

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) begin
        hi_r[i] <= `REG_RST;
      end
    end else if (wrEn && hiSel) begin
      hi_r[hiIdx8[2:0]] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfgB_r    <= `REG_RST;
      cfgC_r    <= `REG_RST;
      intCtrl_r <= `REG_RST;
      thsL_r    <= `REG_RST;
      thsH_r    <= `REG_RST;
    end else begin
      cfgB_r    <= wrCfgB ? wdata : cfgB_r;
      cfgC_r    <= wrCfgC ? wdata : cfgC_r;
      intCtrl_r <= wrCtrl ? wdata : intCtrl_r;
      thsL_r    <= wrThsL ? wdata : thsL_r;
      thsH_r    <= wrThsH ? {1'b0, wdata[6:0]} : thsH_r;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped addresses read as zero
  assign rdMux = hiSel  ? hi_r[hiIdx8[2:0]] :
                 outSel ? (outIdx8[0] ? out_r[outIdx8[2:1]][15:8]
                                      : out_r[outIdx8[2:1]][7:0]) :
                 (addr == `CFG_B_OFS)    ? cfgB_r :
                 (addr == `CFG_C_OFS)    ? cfgC_r :
                 (addr == `INT_CTRL_OFS) ? intCtrl_r :
                 (addr == `INT_SRC_OFS)  ? srcByte :
                 (addr == `THS_L_OFS)    ? thsL_r :
                 (addr == `THS_H_OFS)    ? thsH_r : `REG_RST;

  always_ff @(posedge clk) begin
    if (!nrst)
      rdata_r <= `REG_RST;
    else if (rdEn)
      rdata_r <= rdMux;
  end

  // ----------------------------------------
  // per-axis correction and compare
  // ----------------------------------------
  irq_event_if ev ();

  assign raw[0] = rawX;
  assign raw[1] = rawY;
  assign raw[2] = rawZ;
  assign ev.evalStb = sampleValid;

  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      // offset bytes sit low then high per axis
      assign off[a]   = {hi_r[2*a+1], hi_r[2*a]};
      assign corr[a]  = raw[a] - off[a];
      assign cmpIn[a] = cmpSel ? corr[a] : raw[a];
      // axis enables run x high to z low
      axis_threshold_cmp u_cmp (
        .sample (cmpIn[a]),
        .thresh (thresh),
        .axisEn (axisEn[2-a]),
        .above  (ev.above[2-a]),
        .below  (ev.below[2-a])
      );
    end
  endgenerate

  irq_source u_src (
    .clk     (clk),
    .nrst    (nrst),
    .ev      (ev.src_side),
    .irq_master_enable     (irq_master_enable),
    .latch_select     (latch_select),
    .ovf     (rangeOvf),
    .srcRead (srcRead),
    .srcByte (srcByte),
    .intLvl  (intLvl)
  );

  // ----------------------------------------
  // output data
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        out_r[i] <= `SMP_RST;
      end
      outValid_r <= 1'b0;
    end else begin
      outValid_r <= sampleValid;
      if (sampleValid) begin
        for (int i = 0; i < 3; i++) begin
          out_r[i] <= corr[i];
        end
      end
    end
  end

  assign outX_r = out_r[0];
  assign outY_r = out_r[1];
  assign outZ_r = out_r[2];

  // ----------------------------------------
  // self-test coil and event pin
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      selfTestEn_r      <= 1'b0;
      eventReadyPin_r   <= 1'b0;
      eventReadyPinOe_r <= 1'b0;
    end else begin
      selfTestEn_r      <= cfgC_r[`CFGC_STEST];
      eventReadyPin_r   <= output_polarity_select ? intLvl : !intLvl;
      eventReadyPinOe_r <= cfgC_r[`CFGC_PIN];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence wrCfgC40_s;
    wrCfgC && (wdata == 8'h40);
  endsequence
  sequence settle_s;
    ##2 1'b1;
  endsequence

  hi_store_a: assert property (@(posedge clk) disable iff (!nrst)
    wrEn && (addr == `HI_FIRST_OFS) |=> off[0][7:0] == $past(wdata))
    else $error("hard-iron low byte not stored");
  hi_high_a: assert property (@(posedge clk) disable iff (!nrst)
    wrEn && (addr == `HI_LAST_OFS) |=> off[2][15:8] == $past(wdata))
    else $error("hard-iron high byte misplaced");
  corr_out_a: assert property (@(posedge clk) disable iff (!nrst)
    sampleValid |=> outX_r == 16'($past(rawX) - $past(off[0])) && outValid_r)
    else $error("corrected x output wrong");
  axis_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    !axisEn[2] |-> !ev.above[2] && !ev.below[2])
    else $error("disabled x axis produced a crossing");
  cmp_sel_a: assert property (@(posedge clk) disable iff (!nrst)
    cmpSel && sampleValid |-> cmpIn[1] == 16'(rawY - off[1]))
    else $error("compare source not corrected");
  inside_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    sampleValid && !latch_select && !(|ev.above) && !(|ev.below) |=> !intLvl)
    else $error("event with all samples inside limits");
  pin_level_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> eventReadyPin_r == ($past(output_polarity_select) ? $past(intLvl) : !$past(intLvl)))
    else $error("event pin polarity wrong");
  pin_route_a: assert property (@(posedge clk) disable iff (!nrst)
    wrCfgC40_s |-> settle_s ##0 eventReadyPinOe_r && !selfTestEn_r)
    else $error("config 40h did not route the pin");
  self_test_a: assert property (@(posedge clk) disable iff (!nrst)
    wrCfgC |-> ##2 selfTestEn_r == $past(wdata[`CFGC_STEST], 2))
    else $error("self-test coil enable wrong");
  event_raise_a: assert property (@(posedge clk) disable iff (!nrst)
    sampleValid && irq_master_enable && ev.above[2] |=> intLvl && srcByte[7])
    else $error("x positive crossing not flagged");

  // ----------------------------------------
  // checks on registers, compare path and outputs
  // ----------------------------------------
  // x beyond a limit while the raw sample is compared
  sequence rawXAbove_s;
    sampleValid && irq_master_enable && !cmpSel && axisEn[2] && ($signed(rawX) > $signed({1'b0, thresh}));
  endsequence
  sequence rawXBelow_s;
    sampleValid && irq_master_enable && !cmpSel && axisEn[2] && ($signed(rawX) < -$signed({1'b0, thresh}));
  endsequence

  hi_range_a: assert property (@(posedge clk) disable iff (!nrst)
    wrEn && !hiSel |=> $stable(off[0]) && $stable(off[1]) && $stable(off[2]))
    else $error("write outside range changed an offset");
  ths_high_a: assert property (@(posedge clk) disable iff (!nrst)
    wrThsH |=> !thsH_r[7] && thresh[14:8] == $past(wdata[6:0]))
    else $error("threshold high byte wrong");
  ths_low_a: assert property (@(posedge clk) disable iff (!nrst)
    wrThsL |=> thresh[7:0] == $past(wdata))
    else $error("threshold low byte wrong");
  src_read_a: assert property (@(posedge clk) disable iff (!nrst)
    srcRead |=> rdata_r == $past(srcByte))
    else $error("source read returned wrong byte");
  src_ro_a: assert property (@(posedge clk) disable iff (!nrst)
    wrEn && (addr == `INT_SRC_OFS) && !sampleValid && !rangeOvf && !rdEn |=> $stable(srcByte))
    else $error("write changed the source register");

  cmp_raw_a: assert property (@(posedge clk) disable iff (!nrst)
    !cmpSel && sampleValid |-> cmpIn[1] == rawY)
    else $error("compare source not raw");
  raw_above_a: assert property (@(posedge clk) disable iff (!nrst)
    rawXAbove_s |=> srcByte[7] && srcByte[`SRC_INT])
    else $error("raw x positive crossing not flagged");
  raw_below_a: assert property (@(posedge clk) disable iff (!nrst)
    rawXBelow_s |=> srcByte[4] && srcByte[`SRC_INT])
    else $error("raw x negative crossing not flagged");

  corr_yz_a: assert property (@(posedge clk) disable iff (!nrst)
    sampleValid |=> outY_r == 16'($past(rawY) - $past(off[1]))
                    && outZ_r == 16'($past(rawZ) - $past(off[2])))
    else $error("corrected y or z output wrong");
  out_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !sampleValid |=> $stable(outX_r) && $stable(outY_r) && $stable(outZ_r))
    else $error("output data changed without a sample");
  out_valid_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> outValid_r == $past(sampleValid))
    else $error("output valid not one cycle after sample");

  pin_oe_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> eventReadyPinOe_r == $past(cfgC_r[`CFGC_PIN]))
    else $error("pin enable does not follow config c");
  stest_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> selfTestEn_r == $past(cfgC_r[`CFGC_STEST]))
    else $error("self-test enable does not follow config c");
  range_overflow_flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    srcRead && !rangeOvf |=> !srcByte[`SRC_RANGE_OVERFLOW_FLAG])
    else $error("source read did not clear overflow");
  range_overflow_flag_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    rangeOvf && !irq_master_enable && !srcByte[`SRC_RANGE_OVERFLOW_FLAG] |=> !srcByte[`SRC_RANGE_OVERFLOW_FLAG])
    else $error("overflow flagged with master enable off");
endmodule
`default_nettype wire

// *** test/host_model.sv ***
// host side of the register port: one byte per strobe, write or read
// assumes: strobes are taken on the rising edge of clk, rdata_r lands on that same edge
`timescale 1ns/10ps
`default_nettype none
module host_model
  import mag_irq_pkg::*;
(
  // clock
  input  wire logic  clk,
  // register access
  output logic       wrEn,
  output logic       rdEn,
  output byte_t      addr,
  output byte_t      wdata,
  input  wire byte_t rdata_r
);
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clk);
    #1;
    wrEn = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wrEn = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  task automatic rd(input byte_t a, output byte_t d);
    @(posedge clk);
    #1;
    rdEn = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    d = rdata_r;
    rdEn = 1'b0;
    addr = ~a;
  endtask
endmodule
`default_nettype wire

// *** test/tb_mag_hard_iron_threshold_irq.sv ***
// self-checking bench of the mag post-processing block
// assumes: host_model drives the register port, bench acts as the converter
`timescale 1ns/10ps
`default_nettype none
module tb_mag_hard_iron_threshold_irq;
  import mag_irq_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, sampleValid = 1'b0, rangeOvf = 1'b0;
  logic wrEn, rdEn, outValid_r, selfTestEn_r, eventReadyPin_r, eventReadyPinOe_r;
  sample_t rawX = '0, rawY = '0, rawZ = '0, outX_r, outY_r, outZ_r, cx, cy, cz;
  byte_t addr, wdata, rdata_r, ctrl, e, d;
  sample_t off [3];
  thresh_t th;
  logic [31:0] r;
  logic cmpSel;
  integer seed, errors = 0, checks_done = 0, i, sum0, sum1;
  sample_t corner [5] = '{16'h0081, 16'h0080, 16'hff7f, 16'hff80, 16'h0000};

  always #12.5 clk = ~clk;

  mag_hard_iron_threshold_irq mag_hard_iron_threshold_irq_inst (
    .clk(clk), .nrst(nrst), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wdata(wdata),
    .rdata_r(rdata_r), .sampleValid(sampleValid), .rawX(rawX), .rawY(rawY), .rawZ(rawZ),
    .rangeOvf(rangeOvf), .outValid_r(outValid_r), .outX_r(outX_r), .outY_r(outY_r),
    .outZ_r(outZ_r), .selfTestEn_r(selfTestEn_r), .eventReadyPin_r(eventReadyPin_r),
    .eventReadyPinOe_r(eventReadyPinOe_r));

  host_model host_model_inst (
    .clk(clk), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wdata(wdata), .rdata_r(rdata_r));

  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic [1:0] cmp1(sample_t v, thresh_t t, logic en);
    cmp1 = {en && ($signed(v) > $signed({1'b0, t})), en && ($signed(v) < -$signed({1'b0, t}))};
  endfunction

  function automatic byte_t expSrc(sample_t x, sample_t y, sample_t z, thresh_t t,
                                   axis_t en, logic ov);
    logic [5:0] c;
    c = {cmp1(x, t, en[2]), cmp1(y, t, en[1]), cmp1(z, t, en[0])};
    expSrc = {c[5], c[3], c[1], c[4], c[2], c[0], ov, |c};
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rdChk(input byte_t a, input byte_t exp);
    byte_t v;
    host_model_inst.rd(a, v);
    chk($sformatf("reg %h", a), {8'h00, v}, {8'h00, exp});
  endtask

  // one sample set; corrected data checked one edge after the strobe
  task automatic smp(input sample_t x, input sample_t y, input sample_t z, input logic ov);
    @(posedge clk);
    #1;
    sampleValid = 1'b1;
    rawX = x;
    rawY = y;
    rawZ = z;
    rangeOvf = ov;
    @(posedge clk);
    #1;
    sampleValid = 1'b0;
    rangeOvf = 1'b0;
    chk("outValid", {15'h0, outValid_r}, 16'h0001);
    chk("outX", outX_r, x - off[0]);
    chk("outY", outY_r, y - off[1]);
    chk("outZ", outZ_r, z - off[2]);
  endtask

  task automatic pinChk(input logic act);
    chk("pin", {15'h0, eventReadyPin_r}, {15'h0, ctrl[2] ? act : ~act});
  endtask

  task automatic finish_test;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    errors = errors + 1;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h068b0d28;
    off = '{16'h0000, 16'h0000, 16'h0000};
    ctrl = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (i = 8'h45; i <= 8'h6d; i++) rdChk(i[7:0], 8'h00);
    chk("oe", {15'h0, eventReadyPinOe_r}, 16'h0000);
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      host_model_inst.wr(8'h45 + i[7:0], r[7:0]);
      rdChk(8'h45 + i[7:0], r[7:0]);
      off[i / 2][8 * (i % 2) +: 8] = r[7:0];
    end
    host_model_inst.wr(8'h50, 8'h5a);
    rdChk(8'h50, 8'h00);
    host_model_inst.wr(8'h68, 8'hff);
    rdChk(8'h68, 8'h00);
    host_model_inst.wr(8'h64, 8'hff);
    rdChk(8'h64, 8'h00);
    host_model_inst.wr(8'h66, 8'hff);
    rdChk(8'h66, 8'h7f);
    host_model_inst.wr(8'h62, 8'h40);
    @(posedge clk);
    #1;
    chk("oe", {15'h0, eventReadyPinOe_r}, 16'h0001);
    // coil adds a fixed field; averaged difference must show it
    sum0 = 0;
    sum1 = 0;
    for (i = 0; i < 100; i++) begin
      if (i == 50) begin
        host_model_inst.wr(8'h62, 8'h42);
        @(posedge clk);
        #1;
      end
      smp(16'h0123 + (selfTestEn_r === 1'b1 ? 16'h0100 : 16'h0000), 16'h0000, 16'h0000, 1'b0);
      // offset added back so a wrapped corrected word cannot skew the sums
      if (i < 50) sum0 = sum0 + $signed(16'(outX_r + off[0]));
      else sum1 = sum1 + $signed(16'(outX_r + off[0]));
    end
    chk("coilDiff", 16'((sum1 - sum0) / 50), 16'h0100);
    host_model_inst.wr(8'h62, 8'h40);
    @(posedge clk);
    #1;
    chk("selfTest", {15'h0, selfTestEn_r}, 16'h0000);
    for (i = 0; i < 45; i++) begin
      r = $random(seed);
      ctrl = {r[7] | (i >= 40), r[6:5], 2'b00, r[2], 2'b01};
      cmpSel = r[3] & (i < 40);
      host_model_inst.wr(8'h61, {4'h0, cmpSel, 3'h0});
      host_model_inst.wr(8'h63, ctrl);
      r = $random(seed);
      th = (i >= 40) ? 15'h0080 : r[30:16];
      host_model_inst.wr(8'h65, th[7:0]);
      host_model_inst.wr(8'h66, {1'b0, th[14:8]});
      cx = (i >= 40) ? corner[i - 40] : r[15:0];
      r = $random(seed);
      cy = (i >= 40) ? 16'h0000 : r[15:0];
      cz = (i >= 40) ? 16'h0000 : r[31:16];
      smp(cx, cy, cz, r[4]);
      e = cmpSel ? expSrc(cx - off[0], cy - off[1], cz - off[2], th, ctrl[7:5], r[4])
                 : expSrc(cx, cy, cz, th, ctrl[7:5], r[4]);
      rdChk(8'h64, e);
      pinChk(e[0]);
      d = cx[7:0] - off[0][7:0];
      rdChk(8'h68, d);
    end
    ctrl = 8'he7;
    host_model_inst.wr(8'h61, 8'h00);
    host_model_inst.wr(8'h63, ctrl);
    host_model_inst.rd(8'h64, d);
    smp(16'h00c8, 16'h0000, 16'h0000, 1'b0);
    smp(16'h0000, 16'h0000, 16'h0000, 1'b0);
    @(posedge clk);
    #1;
    pinChk(1'b1);
    rdChk(8'h64, 8'h81);
    rdChk(8'h64, 8'h00);
    pinChk(1'b0);
    smp(16'h0000, 16'h0000, 16'h0000, 1'b1);
    rdChk(8'h64, 8'h02);
    rdChk(8'h64, 8'h00);
    ctrl = 8'he6;
    host_model_inst.wr(8'h63, ctrl);
    smp(16'h00c8, 16'h0000, 16'h0000, 1'b1);
    rdChk(8'h64, 8'h00);
    pinChk(1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
